// ---- design/gpp_pkg.sv ----
// Package with register map and constants of the general pin port
package gpp_pkg;
    localparam int NUM_PINS = 6;
    localparam logic [2:0] ADR_FUNC_SEL = 3'h0;
    localparam logic [2:0] ADR_DIR      = 3'h1;
    localparam logic [2:0] ADR_OUT_SET  = 3'h2;
    localparam logic [2:0] ADR_OUT_CLR  = 3'h3;
    localparam logic [2:0] ADR_LEVEL    = 3'h4;
    localparam int FUNC_SEL_LSB = 0;
    localparam int FUNC_SEL_W   = 3;
    localparam int XCVR_POL_BIT = 3;
    localparam logic [2:0] MODE_GENERAL  = 3'h0;
    localparam logic [2:0] MODE_RTS_CTS  = 3'h1;
    localparam logic [2:0] MODE_DTR_DSR  = 3'h2;
    localparam logic [2:0] MODE_MD_HDX   = 3'h3;
    localparam logic [2:0] MODE_MD_TXEN  = 3'h4;
    localparam int PIN_DSR  = 2;
    localparam int PIN_DTR  = 3;
    localparam int PIN_CTS  = 4;
    localparam int PIN_RTS  = 5;
    localparam int PIN_XCVR = 5;
    localparam logic [7:0] RST_FUNC_SEL = 8'h00;
    localparam logic [5:0] RST_DIR      = 6'h00;
    localparam logic [5:0] RST_OUT      = 6'h00;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ---- design/gpp_general_pin_port.sv ----
// General pin port with Wishbone register access
`timescale 1ns/100ps
// Overview of operation
// - The upper four function select bits read back undefined; here they read the stored value.
// - Direction bits rule only pins not claimed by the function select.
// - Each low direction bit makes its pin an input at zero and an output at one.
// - A one written to the set register drives that pin output high, a zero changes nothing.
// - A one written to the clear register drives that pin output low, a zero changes nothing.
// - The level status register returns the level of every pin in any direction, through a two-flop synchroniser.
// - The three-bit function select gives pins to handshake or transceiver enable; zero frees all.
module gpp_general_pin_port (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [31:0]                    wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic [gpp_pkg::NUM_PINS-1:0]   general_pin_n_i,
    output logic      [gpp_pkg::NUM_PINS-1:0]   general_pin_n_o,
    output logic      [gpp_pkg::NUM_PINS-1:0]   general_pin_n_oe,
    input  wire logic                           flow_rts_n,
    input  wire logic                           flow_dtr_n,
    input  wire logic                           xcvr_tx_active,
    output logic                                flow_cts_n,
    output logic                                flow_dsr_n
);
    import gpp_pkg::*;

    typedef struct packed {
        logic [7:0]          func_sel;
        logic [5:0]          dir;
        logic [5:0]          out;
        logic [5:0]          sync1;
        logic [5:0]          sync2;
        logic                ack;
        logic [31:0]         rdata;
    } gpp_state_s;

    gpp_state_s st_q;
    gpp_state_s st_d;

    // Decoded configuration
    logic [2:0]  mode;
    logic        xcvr_lvl;
    logic [5:0]  claimed;
    logic [5:0]  func_oe;
    logic [5:0]  func_val;

    // Bus decode
    logic        req;
    logic [2:0]  word_adr;
    logic        in_range;
    logic        wr_req;
    logic        rd_req;
    logic        wr_func_sel;
    logic        wr_dir;
    logic        wr_out_set;
    logic        wr_out_clr;

    // Output latch and read data
    logic [5:0]  set_mask;
    logic [5:0]  clr_mask;
    logic [5:0]  out_next;
    logic [31:0] rd_word;

    // Mode field of the function select
    assign mode = st_q.func_sel[FUNC_SEL_LSB +: FUNC_SEL_W];

    // Request taken once per transfer
    assign req      = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign word_adr = wb_adr_i[4:2];
    assign in_range = (wb_adr_i[31:5] == 27'h000_0000);

    // Write needs byte lane zero
    assign wr_req   = req && wb_we_i && wb_sel_i[0] && in_range;

    // Read qualification
    assign rd_req   = req && !wb_we_i && in_range;

    // Transceiver enable polarity
    always_comb begin
        if (st_q.func_sel[XCVR_POL_BIT]) begin
            xcvr_lvl = xcvr_tx_active;
        end else begin
            xcvr_lvl = !xcvr_tx_active;
        end
    end

    // Pins claimed by the function select
    always_comb begin
        claimed = 6'h00;
        unique case (mode)
            MODE_GENERAL: begin
                claimed = 6'h00;
            end
            MODE_RTS_CTS: begin
                claimed[PIN_CTS] = 1'b1;
                claimed[PIN_RTS] = 1'b1;
            end
            MODE_DTR_DSR: begin
                claimed[PIN_DSR] = 1'b1;
                claimed[PIN_DTR] = 1'b1;
            end
            MODE_MD_HDX, MODE_MD_TXEN: begin
                claimed[PIN_XCVR] = 1'b1;
            end
            default: begin
                claimed = 6'h00;
            end
        endcase
    end

    // Drive enable of claimed pins
    always_comb begin
        func_oe = 6'h00;
        unique case (mode)
            MODE_GENERAL: begin
                func_oe = 6'h00;
            end
            MODE_RTS_CTS: begin
                func_oe[PIN_RTS] = 1'b1;
            end
            MODE_DTR_DSR: begin
                func_oe[PIN_DTR] = 1'b1;
            end
            MODE_MD_HDX, MODE_MD_TXEN: begin
                func_oe[PIN_XCVR] = 1'b1;
            end
            default: begin
                func_oe = 6'h00;
            end
        endcase
    end

    // Drive value of claimed pins
    always_comb begin
        func_val = 6'h00;
        unique case (mode)
            MODE_GENERAL: begin
                func_val = 6'h00;
            end
            MODE_RTS_CTS: begin
                func_val[PIN_RTS] = flow_rts_n;
            end
            MODE_DTR_DSR: begin
                func_val[PIN_DTR] = flow_dtr_n;
            end
            MODE_MD_HDX, MODE_MD_TXEN: begin
                func_val[PIN_XCVR] = xcvr_lvl;
            end
            default: begin
                func_val = 6'h00;
            end
        endcase
    end

    // Write strobes per register
    always_comb begin
        wr_func_sel = 1'b0;
        wr_dir      = 1'b0;
        wr_out_set  = 1'b0;
        wr_out_clr  = 1'b0;
        if (wr_req) begin
            unique case (word_adr)
                ADR_FUNC_SEL: begin
                    wr_func_sel = 1'b1;
                end
                ADR_DIR: begin
                    wr_dir = 1'b1;
                end
                ADR_OUT_SET: begin
                    wr_out_set = 1'b1;
                end
                ADR_OUT_CLR: begin
                    wr_out_clr = 1'b1;
                end
                default: begin
                    wr_func_sel = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        if (wr_out_set) begin
            set_mask = wb_dat_i[5:0];
        end else begin
            set_mask = 6'h00;
        end
    end

    always_comb begin
        if (wr_out_clr) begin
            clr_mask = wb_dat_i[5:0];
        end else begin
            clr_mask = 6'h00;
        end
    end

    always_comb begin
        out_next = (st_q.out | set_mask) & ~clr_mask;
    end

    // Read data selection
    always_comb begin
        rd_word = RD_UNMAPPED;
        if (rd_req) begin
            unique case (word_adr)
                ADR_FUNC_SEL: begin
                    rd_word = {24'h00_0000, st_q.func_sel};
                end
                ADR_DIR: begin
                    rd_word = {26'h000_0000, st_q.dir};
                end
                ADR_OUT_SET: begin
                    rd_word = {26'h000_0000, st_q.out};
                end
                ADR_OUT_CLR: begin
                    rd_word = {26'h000_0000, st_q.out};
                end
                ADR_LEVEL: begin
                    rd_word = {26'h000_0000, st_q.sync2};
                end
                default: begin
                    rd_word = RD_UNMAPPED;
                end
            endcase
        end
    end

    // Next state
    always_comb begin
        if (wr_func_sel) begin
            st_d.func_sel = wb_dat_i[7:0];
        end else begin
            st_d.func_sel = st_q.func_sel;
        end
        if (wr_dir) begin
            st_d.dir = wb_dat_i[5:0];
        end else begin
            st_d.dir = st_q.dir;
        end
        st_d.out   = out_next;
        st_d.sync1 = general_pin_n_i;
        st_d.sync2 = st_q.sync1;
        st_d.ack   = req;
        st_d.rdata = rd_word;
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q.func_sel <= RST_FUNC_SEL;
            st_q.dir      <= RST_DIR;
            st_q.out      <= RST_OUT;
            st_q.sync1    <= 6'h00;
            st_q.sync2    <= 6'h00;
            st_q.ack      <= 1'b0;
            st_q.rdata    <= RD_UNMAPPED;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (claimed[i]) begin
                general_pin_n_oe[i] = func_oe[i];
                general_pin_n_o[i]  = func_val[i];
            end else begin
                general_pin_n_oe[i] = st_q.dir[i];
                general_pin_n_o[i]  = st_q.out[i];
            end
        end
    end

    // Handshake inputs to the line logic
    always_comb begin
        flow_cts_n = 1'b0;
        flow_dsr_n = 1'b0;
        if (mode == MODE_RTS_CTS) begin
            flow_cts_n = st_q.sync2[PIN_CTS];
        end
        if (mode == MODE_DTR_DSR) begin
            flow_dsr_n = st_q.sync2[PIN_DSR];
        end
    end

    // Bus outputs
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.rdata;
endmodule

// ---- dv/gpp_general_pin_port_assertions.sv ----
// Checker of the general pin port bus and pins
`timescale 1ns/100ps
module gpp_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [5:0]  general_pin_n_i,
    input wire logic [5:0]  general_pin_n_o,
    input wire logic [5:0]  general_pin_n_oe,
    input wire logic        flow_rts_n,
    input wire logic        flow_dtr_n
);
    import gpp_pkg::*;
    logic       wr;
    logic [2:0] ix;
    assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && !(|wb_adr_i[31:5]);
    assign ix = wb_adr_i[4:2];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_pins_still;
        $stable(general_pin_n_i) [*4];
    endsequence
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_set_high: assert property (wr && ix == ADR_OUT_SET |=>
        ((general_pin_n_o ^ ($past(general_pin_n_o) | 6'($past(wb_dat_i)))) & 6'h03) == 6'h00)
        else $error("set wrong");
    a_clear_low: assert property (wr && ix == ADR_OUT_CLR |=>
        ((general_pin_n_o ^ ($past(general_pin_n_o) & ~6'($past(wb_dat_i)))) & 6'h03) == 6'h00)
        else $error("clear wrong");
    a_dir_pins: assert property (wr && ix == ADR_DIR |=>
        ((general_pin_n_oe ^ 6'($past(wb_dat_i))) & 6'h03) == 6'h00)
        else $error("direction wrong");
    a_rts_claim: assert property (wr && ix == ADR_FUNC_SEL && wb_dat_i[2:0] == MODE_RTS_CTS |=>
        general_pin_n_oe[5:4] == 2'b10 && general_pin_n_o[5] == flow_rts_n)
        else $error("rts claim wrong");
    a_dtr_claim: assert property (wr && ix == ADR_FUNC_SEL && wb_dat_i[2:0] == MODE_DTR_DSR |=>
        general_pin_n_oe[3:2] == 2'b10 && general_pin_n_o[3] == flow_dtr_n)
        else $error("dtr claim wrong");
    a_level_read: assert property (s_pins_still ##0 (wb_ack_o && !wb_we_i && ix == ADR_LEVEL
        && !(|wb_adr_i[31:5])) |-> wb_dat_o[5:0] == general_pin_n_i)
        else $error("level wrong");
endmodule

// ---- dv/gpp_pin_model.sv ----
// External circuitry on the six general pins
`timescale 1ns/100ps
module gpp_pin_model (
    input  wire logic [5:0] pin_drive,
    input  wire logic [5:0] pin_drive_en,
    input  wire logic [5:0] ext_level,
    output logic      [5:0] pin_level
);
    // Undriven pins take the outside level
    assign pin_level = (pin_drive_en & pin_drive) | (~pin_drive_en & ext_level);
endmodule

// ---- dv/test_general_pin_port.sv ----
// Self-checking bench of the general pin port
`timescale 1ns/100ps
module test_general_pin_port;
    import gpp_pkg::*;
    typedef struct {logic we; logic [2:0] ix; logic [7:0] d;} gpp_row_s;
    logic        clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, rts_n = 1, xa = 0;
    logic [31:0] adr = '0, dat = '0, rdat;
    logic [5:0]  ext = 6'h00, pin, po, poe;
    logic [7:0]  q;
    logic        cts, dsr;
    logic [7:0]  claim [5] = '{8'h3F, 8'h2F, 8'h3B, 8'h3F, 8'h3F};
    int          bad_count = 0, samples_checked = 0, cycles = 0;
    gpp_row_s    rows [14] = '{'{1, 3'h1, 8'h3F}, '{0, 3'h1, 8'h3F}, '{1, 3'h2, 8'h05},
        '{0, 3'h2, 8'h05}, '{1, 3'h2, 8'h00}, '{0, 3'h2, 8'h05}, '{1, 3'h3, 8'h04},
        '{0, 3'h3, 8'h01}, '{0, 3'h4, 8'h01}, '{1, 3'h6, 8'hFF}, '{0, 3'h5, 8'h00},
        '{0, 3'h1, 8'h3F}, '{1, 3'h0, 8'h00}, '{0, 3'h0, 8'h00}};
    gpp_general_pin_port dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .general_pin_n_i(pin), .general_pin_n_o(po), .general_pin_n_oe(poe),
        .flow_rts_n(rts_n), .flow_dtr_n(rts_n), .xcvr_tx_active(xa), .flow_cts_n(cts),
        .flow_dsr_n(dsr));
    gpp_pin_model pm (.pin_drive(po), .pin_drive_en(poe), .ext_level(ext), .pin_level(pin));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {27'h0, ix, 2'b00};
        dat <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        if (n >= 20) bad_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({2'b00, poe | po}, 8'h00); // Idle pins
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].ix, rows[i].d);
            if (!rows[i].we) check(q, rows[i].d); // Readback
        end
        check({2'b00, pin}, 8'h01); // Driven pins
        for (int m = 1; m < 5; m++) begin
            bus(1'b1, ADR_FUNC_SEL, 8'(m));
            check({2'b00, poe}, claim[m]); // Claimed pins
        end
        xa <= 1'b1;
        @(posedge clk_sys);
        check({7'h00, po[5]}, 8'h00); // Enable low for send
        bus(1'b1, ADR_FUNC_SEL, 8'h00);
        bus(1'b1, ADR_DIR, 8'h00); // Top bits zero
        ext <= 6'h2A;
        repeat (4) @(posedge clk_sys);
        bus(1'b0, ADR_LEVEL, 8'h00);
        check(q, 8'h2A); // Input levels
        bus(1'b1, ADR_FUNC_SEL, 8'h0B); // Upper bits zero
        check({7'h00, po[5]}, 8'h01); // Enable high for send
        ext <= 6'h14;
        bus(1'b1, ADR_FUNC_SEL, 8'h01);
        repeat (3) @(posedge clk_sys);
        check({6'h00, cts, dsr}, 8'h02); // Clear to send input
        bus(1'b1, ADR_FUNC_SEL, 8'h02);
        check({6'h00, cts, dsr}, 8'h01); // Data set ready input
        bus(1'b1, ADR_OUT_SET, 8'h3F); // Top bits zero
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({2'b00, po}, 8'h00); // Latch low after reset
        complete_run();
    end
endmodule
bind gpp_general_pin_port gpp_chk chk (.*);
